/* File: hdl/frequency_reference_selector.sv */
// Behaviour
// - step input 3 with inputs 1/2 selects presets 5 to 8
// - step input 4 with inputs 1/2 selects presets 9 to 12
// - step inputs 3 and 4 with inputs 1/2 select presets 13 to 16
// - any jog input active selects the jog preset
// - reference never above ceiling percent of maximum output frequency
// - reference never below floor percent of maximum output frequency unless the floor lies above the ceiling
// - three programmable prohibited points keep the reference from settling there unless a ceiling or floor limit lies inside a band
// - one width setting gives the dead-band around every prohibited point
// - hold select 0 disables reference hold, 1 enables it
// - up/down 2 inputs add or remove one bias step
// - ramp select 0 uses current times, 1 uses time set four except while bias mode 1 decays the bias
// - bias mode 0 keeps the bias when up 2 equals down 2
// - bias mode 1 decays bias to zero when up 2 equals down 2
`timescale 1ns/1ps
`default_nettype none
module frequency_reference_selector
  import freq_ref_pkg::*;
(
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // digital input pins, asynchronous
  input wire logic [3:0] step_sel_in,
  input wire logic jog_ref_in,
  input wire logic jog_fwd_in,
  input wire logic jog_rev_in,
  input wire logic up2_in,
  input wire logic down2_in,
  input wire logic hold_in,
  // reference from upstream logic when no preset is chosen
  input wire logic [15:0] base_ref,
  // reference to the speed ramp
  output logic [15:0] freq_ref
);
  logic [15:0] cfg_q [16];
  logic [15:0] preset_q [PRESET_N];
  logic [9:0] meta_q, sync_q;
  logic [3:0] step_s;
  logic jog_s, up2_s, down2_s, hold_s, up2_prev_q, down2_prev_q;
  logic [31:0] prdata_q;
  logic err_q;
  logic [15:0] freq_q;
  logic signed [BW-1:0] bias_target_q, bias_val;
  logic [15:0] sel_ref, biased, jumped, ceil_lim, floor_lim, limited, ramp_period;
  logic signed [BW+1:0] bias_sum;
  logic hold_act, eq_ud, decay, wr_en, setup;

  // address classes: config page, bias readback, preset page
  function automatic logic hit_cfg(input logic [7:0] a);
    hit_cfg = (a[7:6] == PAGE_CFG);
  endfunction

  function automatic logic hit_preset(input logic [7:0] a);
    hit_preset = (a[7:6] == PAGE_PRESET) && (a[5:2] < 4'(PRESET_N));
  endfunction

  // percentage of the maximum output frequency, saturated to 16 bits
  function automatic logic [15:0] pct_of(input logic [15:0] maxf, input logic [15:0] pct);
    logic [31:0] q;
    q = (32'(maxf) * 32'(pct)) / PCT_FULL;
    pct_of = (q > 32'h0000_FFFF) ? 16'hFFFF : q[15:0];
  endfunction

  // move a frequency out of one dead-band to the closer edge
  function automatic logic [15:0] skip_band(input logic [15:0] f, input logic [15:0] pt,
                                            input logic [15:0] width);
    logic [16:0] lo, hi, half;
    half = 17'(width >> 1);
    lo = (17'(pt) > half) ? 17'(pt) - half : 17'h0_0000;
    hi = 17'(pt) + half;
    if (hi > 17'h0_FFFF) begin
      hi = 17'h0_FFFF;
    end
    skip_band = f;
    // a zero point is switched off
    if (pt != 16'h0000 && 17'(f) > lo && 17'(f) < hi) begin
      skip_band = (17'(f) - lo <= hi - 17'(f)) ? lo[15:0] : hi[15:0];
    end
  endfunction

  // two-flop synchronisers for every pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 10'h000;
      sync_q <= 10'h000;
    end else begin
      meta_q <= {hold_in, down2_in, up2_in, jog_rev_in, jog_fwd_in, jog_ref_in, step_sel_in};
      sync_q <= meta_q;
    end
  end

  assign step_s = sync_q[3:0];
  assign jog_s = |sync_q[6:4];
  assign up2_s = sync_q[7];
  assign down2_s = sync_q[8];
  assign hold_s = sync_q[9];

  // apb: zero wait states, read data captured in the setup cycle
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = err_q && psel && penable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end else if (setup) begin
      err_q <= !(hit_cfg(paddr) || hit_preset(paddr) || paddr == ADDR_BIAS);
      if (hit_preset(paddr)) begin
        prdata_q <= {16'h0000, preset_q[paddr[5:2]]};
      end else if (paddr == ADDR_BIAS) begin
        prdata_q <= 32'($signed(bias_val));
      end else if (hit_cfg(paddr) && paddr[5:2] == IDX_STATUS) begin
        prdata_q <= {20'h0_0000, bias_target_q != bias_val, hold_act, sync_q[9:0]};
      end else if (hit_cfg(paddr) && paddr[5:2] == IDX_OUT) begin
        prdata_q <= {16'h0000, freq_q};
      end else if (hit_cfg(paddr)) begin
        prdata_q <= {16'h0000, cfg_q[paddr[5:2]]};
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // configuration words; status and output slots are read-only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 16; i++) begin
        cfg_q[i] <= 16'h0000;
      end
      cfg_q[IDX_MAXF] <= RST_MAXF;
      cfg_q[IDX_CEIL] <= RST_CEIL;
      for (int i = 0; i < 4; i++) begin
        cfg_q[IDX_ACC + 4'(i)] <= RST_TIME;
      end
    end else if (wr_en && hit_cfg(paddr) && paddr[5:2] != IDX_STATUS
                 && paddr[5:2] != IDX_OUT) begin
      cfg_q[paddr[5:2]] <= pwdata[15:0];
    end
  end

  // preset table, step codes 4 to 15 map onto presets 5 to 16
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < PRESET_N; i++) begin
        preset_q[i] <= 16'h0000;
      end
    end else if (wr_en && hit_preset(paddr)) begin
      preset_q[paddr[5:2]] <= pwdata[15:0];
    end
  end

  // source selection: jog first, then step presets, else upstream
  always_comb begin
    if (jog_s) begin
      sel_ref = cfg_q[IDX_JOG];
    end else if (step_s >= STEP_FIRST) begin
      sel_ref = preset_q[step_s - STEP_FIRST];
    end else begin
      sel_ref = base_ref;
    end
  end

  // bias: edge of up 2 or down 2 alone moves the target one step
  assign eq_ud = (up2_s == down2_s);
  assign decay = cfg_q[IDX_CTRL][CTRL_MODE] && eq_ud;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up2_prev_q <= 1'b0;
      down2_prev_q <= 1'b0;
    end else begin
      up2_prev_q <= up2_s;
      down2_prev_q <= down2_s;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bias_target_q <= '0;
    end else if (decay) begin
      bias_target_q <= '0;
    end else if (up2_s && !down2_s && !up2_prev_q) begin
      bias_target_q <= bias_target_q + $signed(BW'(cfg_q[IDX_BSTEP]));
    end else if (down2_s && !up2_s && !down2_prev_q) begin
      bias_target_q <= bias_target_q - $signed(BW'(cfg_q[IDX_BSTEP]));
    end else begin
      // mode 0 with equal inputs, or a level held on, keeps the target
      bias_target_q <= bias_target_q;
    end
  end

  // rising bias uses the accel time, falling bias the decel time
  always_comb begin
    if (!decay && cfg_q[IDX_CTRL][CTRL_RAMP]) begin
      ramp_period = (bias_target_q > bias_val) ? cfg_q[IDX_ACC4] : cfg_q[IDX_DEC4];
    end else begin
      ramp_period = (bias_target_q > bias_val) ? cfg_q[IDX_ACC] : cfg_q[IDX_DEC];
    end
  end

  bias_ramp #(
    .W(BW)
  ) u_ramp (
    .pclk(pclk),
    .presetn(presetn),
    .period(ramp_period),
    .target(bias_target_q),
    .value_q(bias_val)
  );

  // add applied bias, saturating into the unsigned range
  assign bias_sum = $signed({3'b000, sel_ref}) + (BW+2)'(bias_val);
  always_comb begin
    if (bias_sum < 0) begin
      biased = 16'h0000;
    end else if (bias_sum > $signed((BW+2)'(17'h0_FFFF))) begin
      biased = 16'hFFFF;
    end else begin
      biased = bias_sum[15:0];
    end
  end

  // jump bands are applied before the limits so the limits always win
  always_comb begin
    jumped = biased;
    for (int k = 0; k < 3; k++) begin
      jumped = skip_band(jumped, cfg_q[IDX_PT1 + 4'(k)], cfg_q[IDX_WIDTH]);
    end
  end

  assign ceil_lim = pct_of(cfg_q[IDX_MAXF], cfg_q[IDX_CEIL]);
  assign floor_lim = pct_of(cfg_q[IDX_MAXF], cfg_q[IDX_FLOOR]);

  // ceiling checked first, and a floor set above it gives way to the ceiling so it cannot push past it
  always_comb begin
    if (jumped > ceil_lim) begin
      limited = ceil_lim;
    end else if (jumped < floor_lim) begin
      limited = (floor_lim > ceil_lim) ? ceil_lim : floor_lim;
    end else begin
      limited = jumped;
    end
  end

  // hold only acts when enabled in the control word
  assign hold_act = cfg_q[IDX_CTRL][CTRL_HOLD] && hold_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_q <= 16'h0000;
    end else if (!hold_act) begin
      freq_q <= limited;
    end
  end

  assign freq_ref = freq_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_step_three: assert property ((!jog_s && step_s == 4'h4) |-> sel_ref == preset_q[0])
    else $error("step input 3 alone did not give preset 5");
  a_step_four: assert property ((!jog_s && step_s == 4'h9) |-> sel_ref == preset_q[5])
    else $error("step inputs 1 and 4 did not give preset 10");
  a_step_all: assert property ((!jog_s && step_s == 4'hF) |-> sel_ref == preset_q[11])
    else $error("all step inputs did not give preset 16");
  a_step_twelve: assert property ((!jog_s && step_s == 4'hB) |-> sel_ref == preset_q[7])
    else $error("step inputs 1 2 4 did not give preset 12");
  a_jog_wins: assert property (jog_s |-> sel_ref == cfg_q[IDX_JOG])
    else $error("jog input did not select the jog preset");
  a_ceiling_kept: assert property (!hold_act |=> freq_q <= $past(ceil_lim))
    else $error("reference above ceiling");
  a_floor_kept: assert property ((!hold_act && floor_lim <= ceil_lim) |=> freq_q >= $past(floor_lim))
    else $error("reference below floor");
  a_band_three: assert property ((cfg_q[IDX_PT1 + 4'h2] > cfg_q[IDX_WIDTH])
      |-> !(jumped > cfg_q[IDX_PT1 + 4'h2] - (cfg_q[IDX_WIDTH] >> 1)
            && jumped < cfg_q[IDX_PT1 + 4'h2]))
    else $error("reference left below third prohibited point");
  a_hold_freeze: assert property (hold_act |=> $stable(freq_q))
    else $error("reference moved while held");
  a_bias_keep: assert property ((!cfg_q[IDX_CTRL][CTRL_MODE] && eq_ud) |=> $stable(bias_target_q))
    else $error("bias changed in keep mode");
  a_bias_decay: assert property (decay |=> bias_target_q == 0)
    else $error("bias target not cleared in decay mode");
  a_ramp_four: assert property ((cfg_q[IDX_CTRL][CTRL_RAMP] && !decay && bias_target_q > bias_val)
      |-> ramp_period == cfg_q[IDX_ACC4])
    else $error("bias ramp did not use accel time four");

  c_jog: cover property (jog_s ##1 freq_q == cfg_q[IDX_JOG]);
  c_hold: cover property (hold_act [*3]);
  c_decay: cover property (decay && bias_val != 0 ##[1:500] bias_val == 0);
  c_clamp: cover property (jumped > ceil_lim);
endmodule
`default_nettype wire

/* File: hdl/freq_ref_pkg.sv */
package freq_ref_pkg;
  // data widths
  localparam int FW = 16;
  localparam int BW = FW + 1;
  localparam int PRESET_N = 12;
  // word index of each register in the low 64-byte page
  localparam logic [3:0] IDX_CTRL = 4'h0;
  localparam logic [3:0] IDX_STATUS = 4'h1;
  localparam logic [3:0] IDX_MAXF = 4'h2;
  localparam logic [3:0] IDX_CEIL = 4'h3;
  localparam logic [3:0] IDX_FLOOR = 4'h4;
  localparam logic [3:0] IDX_JOG = 4'h5;
  localparam logic [3:0] IDX_PT1 = 4'h6;
  localparam logic [3:0] IDX_WIDTH = 4'h9;
  localparam logic [3:0] IDX_BSTEP = 4'hA;
  localparam logic [3:0] IDX_ACC = 4'hB;
  localparam logic [3:0] IDX_DEC = 4'hC;
  localparam logic [3:0] IDX_ACC4 = 4'hD;
  localparam logic [3:0] IDX_DEC4 = 4'hE;
  localparam logic [3:0] IDX_OUT = 4'hF;
  // byte addresses beyond the low page
  localparam logic [7:0] ADDR_BIAS = 8'h40;
  localparam logic [1:0] PAGE_CFG = 2'h0;
  localparam logic [1:0] PAGE_PRESET = 2'h2;
  // control register fields
  localparam int CTRL_HOLD = 0;
  localparam int CTRL_RAMP = 1;
  localparam int CTRL_MODE = 2;
  // reset values
  localparam logic [15:0] RST_MAXF = 16'h1770;
  localparam logic [15:0] RST_CEIL = 16'h0064;
  localparam logic [15:0] RST_TIME = 16'h0064;
  localparam logic [31:0] PCT_FULL = 32'h0000_0064;
  // first step code that selects a stored preset (step input 3 alone)
  localparam logic [3:0] STEP_FIRST = 4'h4;
endpackage

/* File: hdl/bias_ramp.sv */
`timescale 1ns/1ps
`default_nettype none
module bias_ramp
  import freq_ref_pkg::*;
#(
  parameter int W = BW
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // ramp control: cycles per unit step, and the value to approach
  input wire logic [15:0] period,
  input wire logic signed [W-1:0] target,
  // applied value
  output logic signed [W-1:0] value_q
);
  logic [15:0] cnt_q;
  logic tick;

  // a period of zero is treated as one cycle per unit
  assign tick = (cnt_q + 16'h0001 >= period);

  // rate divider, idle while the value sits on its target
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0000;
    end else if (value_q == target || tick) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // one unit per enable pulse toward the target
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_q <= '0;
    end else if (tick && value_q < target) begin
      value_q <= value_q + W'(1);
    end else if (tick && value_q > target) begin
      value_q <= value_q - W'(1);
    end
  end
endmodule
`default_nettype wire

/* File: testbench/input_controller.sv */
`timescale 1ns/1ps
`default_nettype none
module input_controller (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pin levels requested by the test sequence
  input wire logic [9:0] levels,
  // multi-function digital inputs of the drive
  output logic [3:0] step_sel_in,
  output logic jog_ref_in,
  output logic jog_fwd_in,
  output logic jog_rev_in,
  output logic up2_in,
  output logic down2_in,
  output logic hold_in
);
  logic [9:0] pins_q;

  // output flops: levels move only just after an edge, so the sync stage sees clean steps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_q <= 10'h000;
    end else begin
      pins_q <= levels;
    end
  end

  // pin map of the level vector
  assign step_sel_in = pins_q[3:0];
  assign jog_ref_in = pins_q[4];
  assign jog_fwd_in = pins_q[5];
  assign jog_rev_in = pins_q[6];
  assign up2_in = pins_q[7];
  assign down2_in = pins_q[8];
  assign hold_in = pins_q[9];
endmodule
`default_nettype wire

/* File: testbench/frequency_reference_selector_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module frequency_reference_selector_tb
  import freq_ref_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [9:0] pins = 10'h000;
  logic [15:0] base_ref = 16'h0000;
  logic [31:0] prdata, rdata;
  logic pready, pslverr, rerr;
  logic [3:0] step_sel_in;
  logic jog_ref_in, jog_fwd_in, jog_rev_in, up2_in, down2_in, hold_in;
  logic [15:0] freq_ref, pt;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;

  always #5 pclk = ~pclk;

  input_controller ctl_u (.pclk, .presetn, .levels(pins), .step_sel_in, .jog_ref_in,
    .jog_fwd_in, .jog_rev_in, .up2_in, .down2_in, .hold_in);

  frequency_reference_selector dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .step_sel_in, .jog_ref_in, .jog_fwd_in,
    .jog_rev_in, .up2_in, .down2_in, .hold_in, .base_ref, .freq_ref);

  function automatic logic [7:0] ra(input logic [3:0] i);
    return {2'b00, i, 2'b00};
  endfunction

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // pins pass a controller flop, two sync flops and the output register
  task automatic drive(input logic [9:0] p, input logic [15:0] b);
    @(posedge pclk);
    pins <= p;
    base_ref <= b;
    repeat (5) @(posedge pclk);
  endtask

  task automatic fchk(input logic [9:0] p, input logic [15:0] b, input logic [15:0] e);
    drive(p, b);
    // look half a cycle after the edge that updates the output register
    @(negedge pclk);
    chk({16'h0000, freq_ref}, {16'h0000, e});
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // hang guard, well above the fewer than one thousand cycles the sequence needs
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("FAIL %0t timeout", $time);
      complete_run();
    end
  end

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ra(IDX_MAXF), 32'h0);
    chk(rdata, {16'h0000, RST_MAXF});
    chk({31'h0, rerr}, 32'h0);
    apb(1'b0, ra(IDX_CEIL), 32'h0);
    chk(rdata, {16'h0000, RST_CEIL});
    apb(1'b0, 8'h60, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    done("registers");
    // every step code from 4 up selects preset code+1
    for (int c = 4; c < 16; c++) begin
      apb(1'b1, 8'(8'h80 + 8'(4 * (c - 4))), 32'((c + 1) * 32'h111));
    end
    for (int c = 4; c < 16; c++) begin
      fchk(10'(c), 16'h0005, 16'((c + 1) * 32'h111));
    end
    fchk(10'h000, 16'h0123, 16'h0123);
    done("presets");
    // jog pins override any step code
    apb(1'b1, ra(IDX_JOG), 32'h0777);
    for (int j = 0; j < 3; j++) begin
      fchk(10'((10'h010 << j) | 10'h00F), 16'h0005, 16'h0777);
    end
    done("jog");
    // three points share one width; band edges are open, a tie goes low
    apb(1'b1, ra(IDX_WIDTH), 32'h0040);
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, 8'(ra(IDX_PT1) + 8'(4 * k)), 32'h800 + 32'h400 * k);
    end
    for (int k = 0; k < 3; k++) begin
      pt = 16'(32'h800 + 32'h400 * k);
      fchk(10'h000, pt + 16'h0010, pt + 16'h0020);
      fchk(10'h000, pt - 16'h0010, pt - 16'h0020);
      fchk(10'h000, pt, pt - 16'h0020);
      fchk(10'h000, pt + 16'h0020, pt + 16'h0020);
    end
    done("jump");
    apb(1'b1, ra(IDX_CEIL), 32'd50);
    fchk(10'h00F, 16'h0000, 16'h0BB8);
    apb(1'b0, ra(IDX_OUT), 32'h0);
    chk(rdata, 32'h0000_0BB8);
    apb(1'b1, ra(IDX_FLOOR), 32'd10);
    fchk(10'h000, 16'h0010, 16'h0258);
    apb(1'b1, ra(IDX_CEIL), 32'd100);
    apb(1'b1, ra(IDX_FLOOR), 32'h0);
    done("limits");
    apb(1'b1, ra(IDX_CTRL), 32'h1);
    fchk(10'h000, 16'h0300, 16'h0300);
    fchk(10'h200, 16'h0300, 16'h0300);
    fchk(10'h200, 16'h0400, 16'h0300);
    // status: hold pin seen and hold active, no bias movement
    apb(1'b0, ra(IDX_STATUS), 32'h0);
    chk(rdata, 32'h0000_0600);
    apb(1'b1, ra(IDX_CTRL), 32'h0);
    fchk(10'h200, 16'h0400, 16'h0400);
    done("hold");
    // fast current times so a 16-unit bias settles in well under 40 cycles
    apb(1'b1, ra(IDX_ACC), 32'h1);
    apb(1'b1, ra(IDX_DEC), 32'h1);
    apb(1'b1, ra(IDX_BSTEP), 32'h10);
    drive(10'h080, 16'h0200);
    repeat (40) @(posedge pclk);
    fchk(10'h000, 16'h0200, 16'h0210);
    // the applied bias is read-only, a write must leave it alone
    apb(1'b1, ADDR_BIAS, 32'h0000_0005);
    apb(1'b0, ADDR_BIAS, 32'h0);
    chk(rdata, 32'h10);
    drive(10'h100, 16'h0200);
    repeat (40) @(posedge pclk);
    fchk(10'h000, 16'h0200, 16'h0200);
    apb(1'b1, ra(IDX_CTRL), 32'h4);
    drive(10'h080, 16'h0200);
    repeat (40) @(posedge pclk);
    fchk(10'h080, 16'h0200, 16'h0210);
    drive(10'h000, 16'h0200);
    repeat (40) @(posedge pclk);
    fchk(10'h000, 16'h0200, 16'h0200);
    drive(10'h080, 16'h0200);
    repeat (40) @(posedge pclk);
    drive(10'h180, 16'h0200);
    repeat (40) @(posedge pclk);
    fchk(10'h180, 16'h0200, 16'h0200);
    done("bias");
    // set four keeps its slow reset time, so the bias crawls until select goes back to 0
    apb(1'b1, ra(IDX_CTRL), 32'h2);
    drive(10'h000, 16'h0200);
    drive(10'h080, 16'h0200);
    repeat (30) @(posedge pclk);
    @(negedge pclk);
    chk({16'h0000, freq_ref}, 32'h0000_0200);
    apb(1'b1, ra(IDX_CTRL), 32'h0);
    repeat (40) @(posedge pclk);
    fchk(10'h080, 16'h0200, 16'h0210);
    done("ramp");
    complete_run();
  end
endmodule
`default_nettype wire
